// ---- src/alu_pkg.sv ----
// Package: register map, opcodes and field layout of the nibble ALU
`default_nettype none

package alu_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam int         ADDR_W      = 8;
	localparam logic [7:0] OFF_INSTR   = 8'h00;
	localparam logic [7:0] OFF_ACC     = 8'h04;
	localparam logic [7:0] OFF_EREG    = 8'h08;
	localparam logic [7:0] OFF_CTRL    = 8'h0C;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	localparam logic [7:0] OFF_STACK   = 8'h14;
	localparam logic [7:0] OFF_ROMADDR = 8'h18;
	localparam logic [7:0] OFF_ROMDATA = 8'h1C;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [3:0] OP_LOAD_IMM  = 4'h0;
	localparam logic [3:0] OP_TABLE     = 4'h1;
	localparam logic [3:0] OP_ADD_MEM   = 4'h2;
	localparam logic [3:0] OP_ADD_MEM_C = 4'h3;
	localparam logic [3:0] OP_ADD_IMM   = 4'h4;
	localparam logic [3:0] OP_SET_C     = 4'h5;
	localparam logic [3:0] OP_CLR_C     = 4'h6;
	localparam logic [3:0] OP_TEST_C    = 4'h7;
	localparam logic [3:0] OP_CMPL      = 4'h8;
	localparam logic [3:0] OP_ROT       = 4'h9;
	localparam logic [3:0] OP_LOGIC     = 4'hA;

	localparam logic [1:0] LSEL_XOR = 2'h0;
	localparam logic [1:0] LSEL_OR  = 2'h1;
	localparam logic [1:0] LSEL_AND = 2'h2;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int INSTR_OP_LSB  = 0;
	localparam int INSTR_ARG_LSB = 4;
	localparam int ACC_A_LSB     = 0;
	localparam int ACC_B_LSB     = 4;
	localparam int ACC_C_BIT     = 8;
	localparam int E_LSB         = 0;
	localparam int CTRL_LSEL_LSB = 0;
	localparam int CTRL_EXT_LSB  = 2;
	localparam int CTRL_URS_BIT  = 5;
	localparam int CTRL_RAM_LSB  = 8;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_SKIP_BIT   = 1;
	localparam int ST_CHAIN_BIT  = 2;
	localparam int ST_SERR_BIT   = 3;
	localparam int ST_LVL_LSB    = 4;
	localparam int STK_LSB       = 0;
	localparam int RADDR_LSB     = 0;
	localparam int RDATA_LSB     = 0;
	localparam int ROM_HI_BIT    = 8;
	localparam int ROM_B_LSB     = 4;
	localparam int ROM_A_LSB     = 0;

	// ------------------------------------------------------------
	// Sizes, limits and responses
	// ------------------------------------------------------------
	localparam int         ROM_AW       = 10;
	localparam int         ROM_DW       = 9;
	localparam int         ROM_WORDS    = 1024;
	localparam logic [3:0] STACK_LEVELS = 4'h8;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

`default_nettype wire

// ---- src/rom_if.sv ----
// Interface: port between the datapath and its table memory
`timescale 1ns/1ps
`default_nettype none

interface rom_if;
	logic [alu_pkg::ROM_AW-1:0] addr;
	logic [alu_pkg::ROM_DW-1:0] wdata;
	logic                       we;
	logic                       re;
	logic [alu_pkg::ROM_DW-1:0] rdata;

	modport ctrl (output addr, output wdata, output we, output re,
		input rdata);
	modport mem  (input addr, input wdata, input we, input re,
		output rdata);
endinterface

`default_nettype wire

// ---- src/table_rom.sv ----
// Table memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module table_rom (
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	rom_if.mem        rom
);
	logic [alu_pkg::ROM_DW-1:0] mem_array [0:alu_pkg::ROM_WORDS-1];
	logic [alu_pkg::ROM_DW-1:0] rdata_reg;

	assign rom.rdata = rdata_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rom.we) begin
			mem_array[rom.addr] <= rom.wdata;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_reg <= '0;
		end else if (rom.re) begin
			rdata_reg <= mem_array[rom.addr];
		end
	end
endmodule

`default_nettype wire

// ---- src/nibble_alu_and_rom_lookup.sv ----
// Nibble accumulator datapath with table lookup, AXI4-Lite register slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module nibble_alu_and_rom_lookup (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic [2:0]  s_axi_awprot_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic [2:0]  s_axi_arprot_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [4:0] add4(input logic [3:0] x,
		input logic [3:0] y, input logic cin);
		add4 = {1'b0, x} + {1'b0, y} + {4'h0, cin};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == alu_pkg::OFF_INSTR) || (a == alu_pkg::OFF_ACC) ||
			(a == alu_pkg::OFF_EREG) || (a == alu_pkg::OFF_CTRL) ||
			(a == alu_pkg::OFF_STATUS) || (a == alu_pkg::OFF_STACK) ||
			(a == alu_pkg::OFF_ROMADDR) || (a == alu_pkg::OFF_ROMDATA);
	endfunction

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_ROM_APPLY} exec_state_e;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	exec_state_e state_reg, state_next;
	logic [3:0]  op_reg, op_next, arg_reg, arg_next;
	logic [3:0]  acc_reg, acc_next, b_reg, b_next;
	logic        carry_flag_bit_reg, carry_next;
	logic [7:0]  e_reg, e_next;
	logic [1:0]  logic_select_register_reg, lsel_next;
	logic [2:0]  lookup_extension_bits_reg, ext_next;
	logic        upper_rom_select_flag_reg, urs_next;
	logic [3:0]  ram_at_data_pointer_reg, ram_next;
	logic        skip_reg, skip_next, chain_reg, chain_next;
	logic        serr_reg, serr_next, serr_set;
	logic [3:0]  stack_used_reg, stack_next;
	logic [9:0]  rom_addr_reg, rom_addr_next;
	logic        rom_we_reg;
	logic [8:0]  rom_wdata_reg;

	logic        aw_full_reg, w_full_reg, bvalid_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic        awready_reg, wready_reg, arready_reg, rvalid_reg;
	logic [31:0] rdata_reg;

	rom_if rom_bus ();

	table_rom u_rom (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.rom       (rom_bus)
	);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire        aw_take   = s_axi_awvalid_i & awready_reg;
	wire        w_take    = s_axi_wvalid_i & wready_reg;
	wire        ar_take   = s_axi_arvalid_i & arready_reg;
	// Writes wait for an idle datapath so software never races execution
	wire        wr_fire   = aw_full_reg & w_full_reg & ~bvalid_reg &
		(state_reg == ST_IDLE);
	wire        sel_instr = wr_fire & (awaddr_reg == alu_pkg::OFF_INSTR);
	wire        sel_acc   = wr_fire & (awaddr_reg == alu_pkg::OFF_ACC);
	wire        sel_e     = wr_fire & (awaddr_reg == alu_pkg::OFF_EREG);
	wire        sel_ctrl  = wr_fire & (awaddr_reg == alu_pkg::OFF_CTRL);
	wire        sel_stat  = wr_fire & (awaddr_reg == alu_pkg::OFF_STATUS);
	wire        sel_stack = wr_fire & (awaddr_reg == alu_pkg::OFF_STACK);
	wire        sel_raddr = wr_fire & (awaddr_reg == alu_pkg::OFF_ROMADDR);
	wire        sel_rdata = wr_fire & (awaddr_reg == alu_pkg::OFF_ROMDATA);
	wire        aw_full_next = wr_fire ? 1'b0 : (aw_full_reg | aw_take);
	wire        w_full_next  = wr_fire ? 1'b0 : (w_full_reg | w_take);
	wire        bvalid_next  = wr_fire | (bvalid_reg & ~s_axi_bready_i);
	wire        rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready_i);

	// ------------------------------------------------------------
	// Register words
	// ------------------------------------------------------------
	logic [31:0] instr_w, acc_w, e_w, ctrl_w, stat_w, stack_w, raddr_w;
	wire  [3:0]  level_now = stack_used_reg +
		{3'h0, (state_reg == ST_ROM_APPLY)};

	always_comb begin
		instr_w = '0;
		acc_w   = '0;
		e_w     = '0;
		ctrl_w  = '0;
		stat_w  = '0;
		stack_w = '0;
		raddr_w = '0;
		instr_w[alu_pkg::INSTR_OP_LSB +: 4]  = op_reg;
		instr_w[alu_pkg::INSTR_ARG_LSB +: 4] = arg_reg;
		acc_w[alu_pkg::ACC_A_LSB +: 4]       = acc_reg;
		acc_w[alu_pkg::ACC_B_LSB +: 4]       = b_reg;
		acc_w[alu_pkg::ACC_C_BIT]            = carry_flag_bit_reg;
		e_w[alu_pkg::E_LSB +: 8]             = e_reg;
		ctrl_w[alu_pkg::CTRL_LSEL_LSB +: 2]  = logic_select_register_reg;
		ctrl_w[alu_pkg::CTRL_EXT_LSB +: 3]   = lookup_extension_bits_reg;
		ctrl_w[alu_pkg::CTRL_URS_BIT]        = upper_rom_select_flag_reg;
		ctrl_w[alu_pkg::CTRL_RAM_LSB +: 4]   = ram_at_data_pointer_reg;
		stat_w[alu_pkg::ST_BUSY_BIT]         = (state_reg != ST_IDLE);
		stat_w[alu_pkg::ST_SKIP_BIT]         = skip_reg;
		stat_w[alu_pkg::ST_CHAIN_BIT]        = chain_reg;
		stat_w[alu_pkg::ST_SERR_BIT]         = serr_reg;
		stat_w[alu_pkg::ST_LVL_LSB +: 4]     = level_now;
		stack_w[alu_pkg::STK_LSB +: 4]       = stack_used_reg;
		raddr_w[alu_pkg::RADDR_LSB +: 10]    = rom_addr_reg;
	end

	wire [31:0] read_word =
		(s_axi_araddr_i == alu_pkg::OFF_INSTR)   ? instr_w :
		(s_axi_araddr_i == alu_pkg::OFF_ACC)     ? acc_w   :
		(s_axi_araddr_i == alu_pkg::OFF_EREG)    ? e_w     :
		(s_axi_araddr_i == alu_pkg::OFF_CTRL)    ? ctrl_w  :
		(s_axi_araddr_i == alu_pkg::OFF_STATUS)  ? stat_w  :
		(s_axi_araddr_i == alu_pkg::OFF_STACK)   ? stack_w :
		(s_axi_araddr_i == alu_pkg::OFF_ROMADDR) ? raddr_w : 32'h0000_0000;

	wire [31:0] m_instr = merge(instr_w, wdata_reg, wstrb_reg);
	wire [31:0] m_acc   = merge(acc_w, wdata_reg, wstrb_reg);
	wire [31:0] m_e     = merge(e_w, wdata_reg, wstrb_reg);
	wire [31:0] m_ctrl  = merge(ctrl_w, wdata_reg, wstrb_reg);
	wire [31:0] m_stack = merge(stack_w, wdata_reg, wstrb_reg);
	wire [31:0] m_raddr = merge(raddr_w, wdata_reg, wstrb_reg);
	wire [31:0] m_rdata = merge(32'h0000_0000, wdata_reg, wstrb_reg);
	wire        serr_clr = sel_stat & wstrb_reg[0] &
		wdata_reg[alu_pkg::ST_SERR_BIT];

	// ------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------
	wire       do_skip    = skip_reg |
		((op_reg == alu_pkg::OP_LOAD_IMM) & chain_reg);
	wire       stack_full = (stack_used_reg >= alu_pkg::STACK_LEVELS);
	wire       rom_re     = (state_reg == ST_EXEC) & ~do_skip & ~stack_full &
		(op_reg == alu_pkg::OP_TABLE);
	wire [9:0] lookup_addr = {arg_reg[2:0], lookup_extension_bits_reg,
		acc_reg};
	wire [4:0] sum_mem = add4(acc_reg, ram_at_data_pointer_reg, 1'b0);
	wire [4:0] sum_mc  = add4(acc_reg, ram_at_data_pointer_reg,
		carry_flag_bit_reg);
	wire [4:0] sum_imm = add4(acc_reg, arg_reg, 1'b0);
	wire [3:0] e_low   = e_reg[3:0];
	wire [3:0] logic_res =
		(logic_select_register_reg == alu_pkg::LSEL_OR)  ? (acc_reg | e_low) :
		(logic_select_register_reg == alu_pkg::LSEL_AND) ? (acc_reg & e_low) :
		(acc_reg ^ e_low);

	assign rom_bus.addr  = rom_re ? lookup_addr : rom_addr_reg;
	assign rom_bus.re    = rom_re;
	assign rom_bus.we    = rom_we_reg;
	assign rom_bus.wdata = rom_wdata_reg;

	always_comb begin
		state_next    = state_reg;
		op_next       = op_reg;
		arg_next      = arg_reg;
		acc_next      = acc_reg;
		b_next        = b_reg;
		carry_next    = carry_flag_bit_reg;
		skip_next     = skip_reg;
		chain_next    = chain_reg;
		serr_set      = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (sel_instr) begin
					op_next    = m_instr[alu_pkg::INSTR_OP_LSB +: 4];
					arg_next   = m_instr[alu_pkg::INSTR_ARG_LSB +: 4];
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_next = ST_IDLE;
				skip_next  = 1'b0;
				chain_next = (op_reg == alu_pkg::OP_LOAD_IMM);
				if (!do_skip) begin
					case (op_reg)
						alu_pkg::OP_LOAD_IMM: acc_next = arg_reg;
						alu_pkg::OP_TABLE: begin
							if (stack_full) begin
								serr_set = 1'b1;
							end else begin
								state_next = ST_ROM_APPLY;
							end
						end
						alu_pkg::OP_ADD_MEM: acc_next = sum_mem[3:0];
						alu_pkg::OP_ADD_MEM_C: begin
							acc_next   = sum_mc[3:0];
							carry_next = sum_mc[4];
						end
						alu_pkg::OP_ADD_IMM: begin
							acc_next  = sum_imm[3:0];
							skip_next = ~sum_imm[4];
						end
						alu_pkg::OP_SET_C: carry_next = 1'b1;
						alu_pkg::OP_CLR_C: carry_next = 1'b0;
						alu_pkg::OP_TEST_C: skip_next = ~carry_flag_bit_reg;
						alu_pkg::OP_CMPL: acc_next = ~acc_reg;
						alu_pkg::OP_ROT: begin
							acc_next   = {carry_flag_bit_reg, acc_reg[3:1]};
							carry_next = acc_reg[0];
						end
						alu_pkg::OP_LOGIC: acc_next = logic_res;
						default: ;
					endcase
				end
			end
			ST_ROM_APPLY: begin
				state_next = ST_IDLE;
				if (upper_rom_select_flag_reg) begin
					carry_next = rom_bus.rdata[alu_pkg::ROM_HI_BIT];
				end else begin
					b_next   = rom_bus.rdata[alu_pkg::ROM_B_LSB +: 4];
					acc_next = rom_bus.rdata[alu_pkg::ROM_A_LSB +: 4];
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (sel_acc) begin
			acc_next   = m_acc[alu_pkg::ACC_A_LSB +: 4];
			b_next     = m_acc[alu_pkg::ACC_B_LSB +: 4];
			carry_next = m_acc[alu_pkg::ACC_C_BIT];
		end
	end

	// Error flag: a new error wins over a clear in the same cycle
	assign serr_next     = serr_set | (serr_reg & ~serr_clr);
	assign e_next        = sel_e ? m_e[alu_pkg::E_LSB +: 8] : e_reg;
	assign lsel_next     = sel_ctrl ? m_ctrl[alu_pkg::CTRL_LSEL_LSB +: 2] :
		logic_select_register_reg;
	assign ext_next      = sel_ctrl ? m_ctrl[alu_pkg::CTRL_EXT_LSB +: 3] :
		lookup_extension_bits_reg;
	assign urs_next      = sel_ctrl ? m_ctrl[alu_pkg::CTRL_URS_BIT] :
		upper_rom_select_flag_reg;
	assign ram_next      = sel_ctrl ? m_ctrl[alu_pkg::CTRL_RAM_LSB +: 4] :
		ram_at_data_pointer_reg;
	assign stack_next    = sel_stack ? m_stack[alu_pkg::STK_LSB +: 4] :
		stack_used_reg;
	assign rom_addr_next = sel_raddr ? m_raddr[alu_pkg::RADDR_LSB +: 10] :
		rom_addr_reg;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg          <= ST_IDLE;
			op_reg             <= '0;
			arg_reg            <= '0;
			acc_reg            <= '0;
			b_reg              <= '0;
			carry_flag_bit_reg <= 1'b0;
			skip_reg           <= 1'b0;
			chain_reg          <= 1'b0;
			serr_reg           <= 1'b0;
		end else begin
			state_reg          <= state_next;
			op_reg             <= op_next;
			arg_reg            <= arg_next;
			acc_reg            <= acc_next;
			b_reg              <= b_next;
			carry_flag_bit_reg <= carry_next;
			skip_reg           <= skip_next;
			chain_reg          <= chain_next;
			serr_reg           <= serr_next;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			e_reg                     <= '0;
			logic_select_register_reg <= alu_pkg::LSEL_XOR;
			lookup_extension_bits_reg <= '0;
			upper_rom_select_flag_reg <= 1'b0;
			ram_at_data_pointer_reg   <= '0;
			stack_used_reg            <= '0;
			rom_addr_reg              <= '0;
			rom_we_reg                <= 1'b0;
			rom_wdata_reg             <= '0;
		end else begin
			e_reg                     <= e_next;
			logic_select_register_reg <= lsel_next;
			lookup_extension_bits_reg <= ext_next;
			upper_rom_select_flag_reg <= urs_next;
			ram_at_data_pointer_reg   <= ram_next;
			stack_used_reg            <= stack_next;
			rom_addr_reg              <= rom_addr_next;
			rom_we_reg                <= sel_rdata;
			rom_wdata_reg             <= m_rdata[alu_pkg::RDATA_LSB +: 9];
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			bvalid_reg  <= bvalid_next;
			// Channels stay shut while a response is pending
			awready_reg <= ~aw_full_next & ~bvalid_next;
			wready_reg  <= ~w_full_next & ~bvalid_next;
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			awaddr_reg <= '0;
			wdata_reg  <= '0;
			wstrb_reg  <= '0;
			bresp_reg  <= alu_pkg::RESP_OKAY;
			rdata_reg  <= '0;
			rresp_reg  <= alu_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_reg <= s_axi_awaddr_i;
			end
			if (w_take) begin
				wdata_reg <= s_axi_wdata_i;
				wstrb_reg <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				bresp_reg <= mapped(awaddr_reg) ? alu_pkg::RESP_OKAY :
					alu_pkg::RESP_SLVERR;
			end
			if (ar_take) begin
				rdata_reg <= read_word;
				rresp_reg <= mapped(s_axi_araddr_i) ? alu_pkg::RESP_OKAY :
					alu_pkg::RESP_SLVERR;
			end
		end
	end

	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o  = wready_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign s_axi_rresp_o   = rresp_reg;

endmodule

`default_nettype wire

// ---- verification/nibble_alu_sva.sv ----
// Bus protocol checker for the nibble ALU register slave
`timescale 1ns/1ps
`default_nettype none

module nibble_alu_sva (
	input wire logic        clk_sys_i,
	input wire logic        reset_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	// ------------------------------------------------------------
	// Handshake sequences
	// ------------------------------------------------------------
	sequence s_wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_b_done;
		s_axi_bvalid_o && s_axi_bready_i;
	endsequence
	sequence s_r_done;
		s_axi_rvalid_o && s_axi_rready_i;
	endsequence

	// Busy datapath may stretch the answer by two cycles
	property p_wr_answer;
		s_wr_taken |-> ##[1:4] s_axi_bvalid_o;
	endproperty
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=>
			s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	property p_b_back;
		s_b_done |=> !s_axi_bvalid_o ##1 (s_axi_awready_o && s_axi_wready_o);
	endproperty
	property p_b_block;
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
	endproperty
	property p_r_answer;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=>
			s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	property p_r_back;
		s_r_done |=> !s_axi_rvalid_o ##1 s_axi_arready_o;
	endproperty
	property p_r_block;
		s_axi_rvalid_o |-> !s_axi_arready_o;
	endproperty

	a_wr_answer: assert property (p_wr_answer) else $error("write unanswered");
	a_b_hold: assert property (p_b_hold) else $error("write response moved");
	a_b_back: assert property (p_b_back) else $error("write not reopened");
	a_b_block: assert property (p_b_block) else $error("write open while busy");
	a_r_answer: assert property (p_r_answer) else $error("read data late");
	a_r_hold: assert property (p_r_hold) else $error("read data moved");
	a_r_back: assert property (p_r_back) else $error("read channel not reopened");
	a_r_block: assert property (p_r_block) else $error("read taken while pending");
endmodule

bind nibble_alu_and_rom_lookup nibble_alu_sva nibble_alu_sva_inst (.*);

`default_nettype wire

// ---- verification/tb_nibble_alu_and_rom_lookup.sv ----
// Self-checking random bench for the nibble ALU datapath
`timescale 1ns/1ps
`default_nettype none

module tb_nibble_alu_and_rom_lookup;
	logic        clk_sys_i, reset_i, s_axi_awvalid_i, s_axi_awready_o;
	logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
	logic        s_axi_rvalid_o, s_axi_rready_i, skip, chain, ta, tw, hs;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [2:0]  s_axi_awprot_i, s_axi_arprot_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd, r;
	logic [3:0]  s_axi_wstrb_i, op, n, e;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
	logic [8:0]  acc, w;
	logic [11:0] ctrl;
	int          errors, n_checks, cycles;
	integer      seed;

	nibble_alu_and_rom_lookup nibble_alu_and_rom_lookup_inst (.*);

	// ------------------------------------------------------------
	// Clock, timeout and report
	// ------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// Longest run is well under half this
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk_w(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask

	task automatic chk_r(input logic [1:0] g, input logic [1:0] x);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("[FAIL] %0t resp %h exp %h", $time, g, x);
		end
	endtask

	// ------------------------------------------------------------
	// Bus cycles; answers sampled at the rising edge they stand on
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		hs = 1'b0;
		while (!hs) begin
			@(posedge clk_sys_i);
			ta = s_axi_awvalid_i && s_axi_awready_o;
			tw = s_axi_wvalid_i && s_axi_wready_o;
			hs = s_axi_bvalid_o;
			resp = s_axi_bresp_o;
			if (ta)
				s_axi_awvalid_i <= 1'b0;
			if (tw)
				s_axi_wvalid_i <= 1'b0;
		end
		s_axi_bready_i <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		hs = 1'b0;
		while (!hs) begin
			@(posedge clk_sys_i);
			ta = s_axi_arvalid_i && s_axi_arready_o;
			hs = s_axi_rvalid_o;
			rd = s_axi_rdata_o;
			resp = s_axi_rresp_o;
			if (ta)
				s_axi_arvalid_i <= 1'b0;
		end
		s_axi_rready_i <= 1'b0;
	endtask

	// Returns {skip, carry, B, A}
	function automatic logic [9:0] exec(input logic [3:0] o, input logic [3:0] k,
		input logic [8:0] x, input logic [11:0] c, input logic [3:0] ev,
		input logic [8:0] m);
		logic [4:0] s;
		s = {1'b0, x[3:0]} + ((o == 4'h4) ? k : c[11:8]) + ((o == 4'h3) & x[8]);
		case (o)
			4'h0: return {1'b0, x[8:4], k};
			4'h1: return c[5] ? {1'b0, m[8], x[7:0]} :
				{1'b0, x[8], m[7:0]};
			4'h2: return {1'b0, x[8:4], s[3:0]};
			4'h3: return {1'b0, s[4], x[7:4], s[3:0]};
			4'h4: return {~s[4], x[8:4], s[3:0]};
			4'h5: return {2'b01, x[7:0]};
			4'h6: return {2'b00, x[7:0]};
			4'h7: return {~x[8], x};
			4'h8: return {1'b0, x[8:4], ~x[3:0]};
			4'h9: return {1'b0, x[0], x[7:4], x[8], x[3:1]};
			4'hA: return {1'b0, x[8:4], (c[1:0] == 2'h1) ? x[3:0] | ev :
				(c[1:0] == 2'h2) ? x[3:0] & ev : x[3:0] ^ ev};
			default: return {1'b0, x};
		endcase
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 55412;
		{errors, n_checks, cycles} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i} = 10'h000;
		{s_axi_araddr_i, s_axi_wdata_i} = 40'h00_0000_0000;
		s_axi_awprot_i = 3'h0;
		s_axi_arprot_i = 3'h0;
		s_axi_wstrb_i = 4'hF;
		reset_i = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd_reg(alu_pkg::OFF_ACC);
		chk_w(rd, 32'h0000_0000);
		rd_reg(8'h40);
		chk_r(resp, alu_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0000_00FF);
		chk_r(resp, alu_pkg::RESP_SLVERR);
		// Full stack: lookup must not happen, error flag raised
		wr(alu_pkg::OFF_STACK, 32'h0000_0008);
		wr(alu_pkg::OFF_INSTR, 32'h0000_0001);
		rd_reg(alu_pkg::OFF_STATUS);
		chk_w(rd & 32'h0000_0008, 32'h0000_0008);
		rd_reg(alu_pkg::OFF_ACC);
		chk_w(rd, 32'h0000_0000);
		wr(alu_pkg::OFF_STATUS, 32'h0000_0008);
		wr(alu_pkg::OFF_STACK, 32'h0000_0007);
		{acc, ctrl, e, skip, chain} = '0;
		for (int i = 0; i < 500; i++) begin
			r = $random(seed);
			op = (r[5:4] == 2'h0) ? 4'h0 : r[3:0];
			n = r[11:8];
			if (r[6]) begin
				ctrl = r[23:12] & 12'hF3F;
				e = r[27:24];
				wr(alu_pkg::OFF_CTRL, {20'h0_0000, ctrl});
				wr(alu_pkg::OFF_EREG, {28'h000_0000, e});
			end
			if (r[7]) begin
				acc = 9'($random(seed));
				wr(alu_pkg::OFF_ACC, {23'h00_0000, acc});
			end
			if (op == 4'h1) begin
				w = 9'($random(seed));
				wr(alu_pkg::OFF_ROMADDR, {22'h0, n[2:0], ctrl[4:2], acc[3:0]});
				wr(alu_pkg::OFF_ROMDATA, {23'h00_0000, w});
			end
			wr(alu_pkg::OFF_INSTR, {24'h00_0000, n, op});
			if (skip || (op == 4'h0 && chain))
				skip = 1'b0;
			else
				{skip, acc} = exec(op, n, acc, ctrl, e, w);
			chain = (op == 4'h0);
			rd_reg(alu_pkg::OFF_ACC);
			chk_w(rd, {23'h00_0000, acc});
			rd_reg(alu_pkg::OFF_STATUS);
			chk_w({29'h0, rd[3:1]}, {30'h0, chain, skip});
		end
		end_sim();
	end
endmodule

`default_nettype wire
